/* File: hdl/t1_cond_pkg.sv */
// Constants shared by the T1 conditioning block and its helpers
`default_nettype none
package t1_cond_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_IDLE      = 8'h04;
	localparam logic [7:0] OFF_COND_DATA = 8'h08;
	localparam logic [7:0] OFF_COND_SIG  = 8'h0c;
	localparam logic [7:0] OFF_SLOT_MAP  = 8'h10;
	localparam logic [7:0] OFF_STATUS    = 8'h14;

	// Control register fields
	localparam int CTRL_LINE_LSB    = 0;
	localparam int CTRL_CAS_BIT     = 2;
	localparam int CTRL_RESTORE_BIT = 3;

	// Status register fields
	localparam int ST_RED_BIT     = 0;
	localparam int ST_LINE_BIT    = 1;
	localparam int ST_OVR_BIT     = 2;
	localparam int ST_UND_BIT     = 3;
	localparam int ST_AIS_BIT     = 4;
	localparam int ST_CASM_BIT    = 5;
	localparam int ST_LEVEL_LSB   = 8;

	// Line types
	typedef enum logic [1:0] {
		LINE_D4       = 2'h0,
		LINE_ESF      = 2'h1,
		LINE_UNFRAMED = 2'h2
	} line_type_t;

	// Reset values
	localparam logic [1:0]  RST_LINE_TYPE = 2'h1;
	localparam logic        RST_CAS_EN    = 1'b1;
	localparam logic        RST_RESTORE   = 1'b0;
	localparam logic [7:0]  RST_IDLE      = 8'h7e;
	localparam logic [7:0]  RST_COND_DATA = 8'h7f;
	localparam logic [3:0]  RST_COND_SIG  = 4'h1;
	localparam logic [23:0] RST_SLOT_MAP  = 24'hffffff;

	// Sizes
	localparam int SLOTS      = 24;
	localparam int FIFO_DEPTH = 32;
	localparam logic [7:0] AIS_BYTE  = 8'hff;
	localparam logic [3:0] D4_SIG_MASK = 4'h3;

	// Timing
	localparam longint unsigned CLK_HZ          = 200_000_000;
	localparam longint unsigned RESTORE_SHORT_S = 1;
	localparam longint unsigned RESTORE_LONG_S  = 10;
	localparam longint unsigned RESTORE_SHORT_CYC = RESTORE_SHORT_S * CLK_HZ;
	localparam longint unsigned RESTORE_LONG_CYC  = RESTORE_LONG_S * CLK_HZ;
endpackage : t1_cond_pkg
`default_nettype wire

/* File: hdl/cond_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cond_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic      [WIDTH-1:0]         out_data,
	output logic      [$clog2(DEPTH):0]   level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} fifo_state_t;

	fifo_state_t st_r;
	fifo_state_t st_nxt;
	logic        push;
	logic        pop;

	assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_r.cnt != '0);
	assign out_data  = st_r.mem[st_r.rp];
	assign level     = st_r.cnt;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb
	begin
		st_nxt = st_r;
		if (push)
		begin
			st_nxt.mem[st_r.wp] = in_data;
			st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
		end
		if (pop)
			st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
		st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule : cond_fifo
`default_nettype wire

/* File: hdl/red_alarm_timer.sv */
// Red alarm hold with selectable recovery interval
`timescale 1ns/1ps
`default_nettype none
module red_alarm_timer #(
	parameter longint unsigned SHORT_CYC = t1_cond_pkg::RESTORE_SHORT_CYC,
	parameter longint unsigned LONG_CYC  = t1_cond_pkg::RESTORE_LONG_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic alarm_raw,
	input  wire logic sel_long,
	output logic      red_alarm
);
	typedef struct packed {
		logic        red;
		logic [31:0] cnt;
	} timer_state_t;

	timer_state_t st_r;
	timer_state_t st_nxt;
	logic [31:0]  limit;

	assign limit     = sel_long ? 32'(LONG_CYC) : 32'(SHORT_CYC);
	assign red_alarm = st_r.red;

	// Alarm asserts at once; clears only after a full clean interval
	always_comb
	begin
		st_nxt = st_r;
		if (alarm_raw)
		begin
			st_nxt.red = 1'b1;
			st_nxt.cnt = '0;
		end
		else if (st_r.red)
		begin
			if (st_r.cnt + 32'h1 >= limit)
			begin
				st_nxt.red = 1'b0;
				st_nxt.cnt = '0;
			end
			else
				st_nxt.cnt = st_r.cnt + 32'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule : red_alarm_timer
`default_nettype wire

/* File: hdl/t1_fault_conditioning_idle_insert.sv */
// T1-side idle insertion, fault conditioning and framer mode control
// Operation
// - Red alarm recovery is one or ten seconds, one second after reset
// - Unused transmit timeslots carry the idle byte, reset value 7e
// - Signaling enabled: framer in CAS mode, fractional-with-CAS operation
// - Signaling disabled: no CAS in framer, plain fractional, no signaling path
// - Line LOS, LOF or AIS: bytes toward IP become conditioning byte 7f
// - Buffer overrun or underrun: bytes toward the line become conditioning byte
// - Unframed: conditioning is sent as AIS, not as a byte pattern
// - Unframed: AIS on line loss of signal or buffer overrun or underrun
// - Line fault forces signaling toward IP to code; AB for D4, ABCD for ESF
// - Buffer overrun or underrun forces signaling toward the line to code
// - Line types D4, ESF and unframed pass-through
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module t1_fault_conditioning_idle_insert #(
	parameter longint unsigned RESTORE_SHORT_CYC = t1_cond_pkg::RESTORE_SHORT_CYC,
	parameter longint unsigned RESTORE_LONG_CYC  = t1_cond_pkg::RESTORE_LONG_CYC,
	parameter int              FIFO_DEPTH        = t1_cond_pkg::FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Packet side into the receive buffer
	input  wire logic        pkt_valid,
	output logic             pkt_ready,
	input  wire logic [7:0]  pkt_data,
	input  wire logic [3:0]  pkt_sig,
	// T1 transmit slot requests and answers
	input  wire logic        tx_slot_req,
	input  wire logic [4:0]  tx_slot_idx,
	output logic             tx_valid,
	output logic      [7:0]  tx_data,
	output logic      [3:0]  tx_sig,
	output logic             tx_ais,
	// T1 receive side and line alarms
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic [3:0]  rx_sig,
	input  wire logic        line_los,
	input  wire logic        line_lof,
	input  wire logic        line_ais,
	// Toward the IP path
	output logic             ip_valid,
	output logic      [7:0]  ip_data,
	output logic      [3:0]  ip_sig,
	// Framer configuration
	output logic      [1:0]  framer_line_type,
	output logic             framer_cas_mode,
	output logic             red_alarm
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	typedef struct packed {
		logic [1:0]  line_type;
		logic        cas_en;
		logic        restore_long;
		logic [7:0]  idle_code;
		logic [7:0]  cond_data;
		logic [3:0]  fault_signaling_fill_code;
		logic [23:0] slot_map;
		logic [31:0] rdata;
		logic        ovr;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic [3:0]  tx_sig;
		logic        tx_ais;
		logic        ip_valid;
		logic [7:0]  ip_data;
		logic [3:0]  ip_sig;
	} core_state_t;

	core_state_t st_r;
	core_state_t st_nxt;

	logic          fifo_out_valid;
	logic          fifo_out_ready;
	logic [11:0]   fifo_out;
	logic [LW-1:0] fifo_level;
	logic          unframed;
	logic          is_d4;
	logic          line_fault;
	logic          buf_fault;
	logic          slot_used;
	logic          setup;
	logic          access;
	logic          mapped;

	// Signaling carried: none without CAS, AB only for D4
	function automatic logic [3:0] sig_fit(
		input logic [3:0] s,
		input logic       cas,
		input logic       d4
	);
		logic [3:0] r;
		r = cas ? s : 4'h0;
		if (d4)
			r = r & t1_cond_pkg::D4_SIG_MASK;
		return r;
	endfunction : sig_fit

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == t1_cond_pkg::OFF_CTRL) || (a == t1_cond_pkg::OFF_IDLE) ||
			(a == t1_cond_pkg::OFF_COND_DATA) || (a == t1_cond_pkg::OFF_COND_SIG) ||
			(a == t1_cond_pkg::OFF_SLOT_MAP) || (a == t1_cond_pkg::OFF_STATUS);
	endfunction : is_mapped

	// Each entry holds a byte with its ABCD bits on top
	cond_fifo #(
		.WIDTH (12),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (pkt_valid),
		.in_ready  (pkt_ready),
		.in_data   ({pkt_sig, pkt_data}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out),
		.level     (fifo_level)
	);

	// Only loss of signal or frame starts the red alarm hold
	red_alarm_timer #(
		.SHORT_CYC (RESTORE_SHORT_CYC),
		.LONG_CYC  (RESTORE_LONG_CYC)
	) u_red (
		.pclk      (pclk),
		.presetn   (presetn),
		.alarm_raw (line_los | line_lof),
		.sel_long  (st_r.restore_long),
		.red_alarm (red_alarm)
	);

	// Fault sources; in framed modes the red alarm hold keeps the IP side conditioned
	assign unframed   = (st_r.line_type == t1_cond_pkg::LINE_UNFRAMED);
	assign is_d4      = (st_r.line_type == t1_cond_pkg::LINE_D4);
	assign line_fault = line_los | line_lof | line_ais | red_alarm;
	assign buf_fault  = st_r.ovr | ~fifo_out_valid;
	// Indices past the last slot count as used only in unframed mode
	assign slot_used  = unframed | ((tx_slot_idx < 5'(t1_cond_pkg::SLOTS)) &&
		st_r.slot_map[tx_slot_idx]);
	// Draining continues during overrun so the fault can clear
	assign fifo_out_ready = tx_slot_req & slot_used;

	// Zero wait states: each access completes at its first access edge
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign mapped  = is_mapped(paddr);
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata  = st_r.rdata;

	// Framer sees CAS only in framed modes
	assign framer_line_type = st_r.line_type;
	assign framer_cas_mode  = st_r.cas_en & ~unframed;
	assign tx_valid = st_r.tx_valid;
	assign tx_data  = st_r.tx_data;
	assign tx_sig   = st_r.tx_sig;
	assign tx_ais   = st_r.tx_ais;
	assign ip_valid = st_r.ip_valid;
	assign ip_data  = st_r.ip_data;
	assign ip_sig   = st_r.ip_sig;

	always_comb
	begin
		st_nxt = st_r;

		// Register writes take effect in the access phase
		if (access && pwrite)
		begin
			case (paddr)
				t1_cond_pkg::OFF_CTRL:
				begin
					st_nxt.line_type = pwdata[t1_cond_pkg::CTRL_LINE_LSB +: 2];
					st_nxt.cas_en = pwdata[t1_cond_pkg::CTRL_CAS_BIT];
					st_nxt.restore_long = pwdata[t1_cond_pkg::CTRL_RESTORE_BIT];
				end
				t1_cond_pkg::OFF_IDLE:
				begin
					st_nxt.idle_code = pwdata[7:0];
				end
				t1_cond_pkg::OFF_COND_DATA:
				begin
					st_nxt.cond_data = pwdata[7:0];
				end
				t1_cond_pkg::OFF_COND_SIG:
				begin
					st_nxt.fault_signaling_fill_code = pwdata[3:0];
				end
				t1_cond_pkg::OFF_SLOT_MAP:
				begin
					st_nxt.slot_map = pwdata[23:0];
				end
				// Status is read-only and unmapped offsets take no write
				default:
				begin
					st_nxt.slot_map = st_r.slot_map;
				end
			endcase
		end

		// Read data is captured in the setup phase
		if (setup && !pwrite)
		begin
			st_nxt.rdata = 32'h0;
			case (paddr)
				t1_cond_pkg::OFF_CTRL:
				begin
					st_nxt.rdata[t1_cond_pkg::CTRL_LINE_LSB +: 2] = st_r.line_type;
					st_nxt.rdata[t1_cond_pkg::CTRL_CAS_BIT] = st_r.cas_en;
					st_nxt.rdata[t1_cond_pkg::CTRL_RESTORE_BIT] = st_r.restore_long;
				end
				t1_cond_pkg::OFF_IDLE:
				begin
					st_nxt.rdata[7:0] = st_r.idle_code;
				end
				t1_cond_pkg::OFF_COND_DATA:
				begin
					st_nxt.rdata[7:0] = st_r.cond_data;
				end
				t1_cond_pkg::OFF_COND_SIG:
				begin
					st_nxt.rdata[3:0] = st_r.fault_signaling_fill_code;
				end
				t1_cond_pkg::OFF_SLOT_MAP:
				begin
					st_nxt.rdata[23:0] = st_r.slot_map;
				end
				t1_cond_pkg::OFF_STATUS:
				begin
					st_nxt.rdata[t1_cond_pkg::ST_RED_BIT]  = red_alarm;
					st_nxt.rdata[t1_cond_pkg::ST_LINE_BIT] = line_fault;
					st_nxt.rdata[t1_cond_pkg::ST_OVR_BIT]  = st_r.ovr;
					st_nxt.rdata[t1_cond_pkg::ST_UND_BIT]  = ~fifo_out_valid;
					st_nxt.rdata[t1_cond_pkg::ST_AIS_BIT]  = st_r.tx_ais;
					st_nxt.rdata[t1_cond_pkg::ST_CASM_BIT] = framer_cas_mode;
					st_nxt.rdata[t1_cond_pkg::ST_LEVEL_LSB +: LW] = fifo_level;
				end
				default:
				begin
					st_nxt.rdata = 32'h0;
				end
			endcase
		end

		// Overrun: a byte offered while the buffer is full; held until room returns
		if (pkt_ready)
			st_nxt.ovr = 1'b0;
		if (pkt_valid && !pkt_ready)
			st_nxt.ovr = 1'b1;

		// Transmit toward the T1 line
		st_nxt.tx_valid = tx_slot_req;
		// AIS flag tracks faults every cycle, not only on slot requests
		if (unframed)
			st_nxt.tx_ais = line_los | buf_fault;
		else
			st_nxt.tx_ais = 1'b0;
		// Framed priority: unused slot, then buffer fault, then live data
		if (tx_slot_req)
		begin
			if (unframed)
			begin
				// Every slot carries data; conditioning goes out as all ones
				if (line_los || buf_fault)
					st_nxt.tx_data = t1_cond_pkg::AIS_BYTE;
				else
					st_nxt.tx_data = fifo_out[7:0];
				st_nxt.tx_sig = 4'h0;
			end
			else if (!slot_used)
			begin
				st_nxt.tx_data = st_r.idle_code;
				st_nxt.tx_sig = 4'h0;
			end
			else if (buf_fault)
			begin
				st_nxt.tx_data = st_r.cond_data;
				st_nxt.tx_sig = sig_fit(st_r.fault_signaling_fill_code, st_r.cas_en,
					is_d4);
			end
			else
			begin
				st_nxt.tx_data = fifo_out[7:0];
				st_nxt.tx_sig = sig_fit(fifo_out[11:8], st_r.cas_en, is_d4);
			end
		end

		// Toward the IP path
		st_nxt.ip_valid = rx_valid;
		if (rx_valid)
		begin
			if (unframed)
			begin
				// Only loss of signal turns unframed traffic into all ones
				st_nxt.ip_data = line_los ? t1_cond_pkg::AIS_BYTE : rx_data;
				st_nxt.ip_sig = 4'h0;
			end
			else if (line_fault)
			begin
				st_nxt.ip_data = st_r.cond_data;
				st_nxt.ip_sig = sig_fit(st_r.fault_signaling_fill_code, st_r.cas_en,
					is_d4);
			end
			else
			begin
				st_nxt.ip_data = rx_data;
				st_nxt.ip_sig = sig_fit(rx_sig, st_r.cas_en, is_d4);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Configuration at its defaults, traffic state cleared
			st_r                           <= '0;
			st_r.line_type                 <= t1_cond_pkg::RST_LINE_TYPE;
			st_r.cas_en                    <= t1_cond_pkg::RST_CAS_EN;
			st_r.restore_long              <= t1_cond_pkg::RST_RESTORE;
			st_r.idle_code                 <= t1_cond_pkg::RST_IDLE;
			st_r.cond_data                 <= t1_cond_pkg::RST_COND_DATA;
			st_r.fault_signaling_fill_code <= t1_cond_pkg::RST_COND_SIG;
			st_r.slot_map                  <= t1_cond_pkg::RST_SLOT_MAP;
		end
		else
			st_r <= st_nxt;
	end
endmodule : t1_fault_conditioning_idle_insert
`default_nettype wire

/* File: test/t1_cond_asserts.sv */
// Port-level assertions for the T1 conditioning block
`timescale 1ns/1ps
`default_nettype none
module t1_cond_asserts (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       tx_slot_req,
	input wire logic       tx_valid,
	input wire logic       tx_ais,
	input wire logic       rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic       ip_valid,
	input wire logic [7:0] ip_data,
	input wire logic [3:0] ip_sig,
	input wire logic       line_los,
	input wire logic       line_lof,
	input wire logic       line_ais,
	input wire logic [1:0] framer_line_type,
	input wire logic       framer_cas_mode,
	input wire logic       red_alarm
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_tx_answer_next: assert property (tx_slot_req |=> tx_valid)
		else $error("slot request not answered next cycle");
	a_ip_answer_next: assert property (rx_valid |=> ip_valid)
		else $error("receive byte not forwarded next cycle");
	a_unframed_ais_on: assert property (framer_line_type == 2'h2 && line_los |=> tx_ais)
		else $error("no AIS on loss of signal while unframed");
	a_framed_no_ais: assert property (framer_line_type != 2'h2 |=> !tx_ais)
		else $error("AIS sent while framed");
	a_unframed_no_cas: assert property (framer_line_type == 2'h2 |-> !framer_cas_mode)
		else $error("CAS mode set while unframed");
	a_red_on_loss: assert property (line_los || line_lof |=> red_alarm)
		else $error("red alarm not raised on line loss");
	a_ip_unframed_los: assert property (rx_valid && framer_line_type == 2'h2 && line_los
		|=> ip_data == 8'hff)
		else $error("unframed byte toward IP not all ones on loss");
	a_ip_unframed_pass: assert property (rx_valid && framer_line_type == 2'h2 && !line_los
		|=> ip_data == $past(rx_data))
		else $error("unframed byte toward IP not passed through");
	a_d4_sig_mask: assert property (rx_valid && line_ais && framer_line_type == 2'h0
		|=> ip_sig[3:2] == 2'h0)
		else $error("D4 signaling toward IP uses C or D bits");
endmodule : t1_cond_asserts
bind t1_fault_conditioning_idle_insert t1_cond_asserts t1_cond_asserts_inst (.pclk, .presetn,
	.tx_slot_req, .tx_valid, .tx_ais, .rx_valid, .rx_data, .ip_valid, .ip_data, .ip_sig,
	.line_los, .line_lof, .line_ais, .framer_line_type, .framer_cas_mode, .red_alarm);
`default_nettype wire

/* File: test/t1_line_model.sv */
// T1 line equipment model asking for slots and sending bytes
`timescale 1ns/1ps
`default_nettype none
module t1_line_model (
	input  wire logic       pclk,
	output logic            tx_slot_req,
	output logic      [4:0] tx_slot_idx,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic [3:0] tx_sig,
	input  wire logic       tx_ais,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic      [3:0] rx_sig
);
	initial
	begin
		tx_slot_req = 1'b0;
		tx_slot_idx = 5'h0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_sig = 4'h0;
	end
	task automatic ask(input logic [4:0] idx, output logic [12:0] ans, output logic ok);
		@(posedge pclk);
		tx_slot_req <= 1'b1;
		tx_slot_idx <= idx;
		@(posedge pclk);
		tx_slot_req <= 1'b0;
		tx_slot_idx <= ~idx;
		@(negedge pclk);
		ok = tx_valid;
		ans = {tx_ais, tx_sig, tx_data};
	endtask : ask
	// Released lines show the inverse so stale data is never mistaken
	task automatic send(input logic [11:0] v);
		@(posedge pclk);
		rx_valid <= 1'b1;
		{rx_sig, rx_data} <= v;
		@(posedge pclk);
		rx_valid <= 1'b0;
		{rx_sig, rx_data} <= ~v;
		@(negedge pclk);
	endtask : send
endmodule : t1_line_model
`default_nettype wire

/* File: test/t1_fault_conditioning_idle_insert_tb_top.sv */
// Self-checking bench for the T1 conditioning block
`timescale 1ns/1ps
`default_nettype none
module t1_fault_conditioning_idle_insert_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pkt_valid, pkt_ready;
	logic        tx_slot_req, tx_valid, tx_ais, rx_valid, ip_valid, framer_cas_mode, red_alarm;
	logic        line_los, line_lof, line_ais, er, ok, cas;
	logic [7:0]  paddr, pkt_data, tx_data, rx_data, ip_data, idle, cd;
	logic [3:0]  pkt_sig, tx_sig, rx_sig, ip_sig, cs;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  tx_slot_idx;
	logic [1:0]  framer_line_type, lt;
	logic [12:0] ans, e;
	logic [11:0] v;
	logic [11:0] q[$];
	int          err_count, cmp_count, i, k;
	integer      seed;
	logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
	logic [31:0] rv[6] = '{32'h5, 32'h7e, 32'h7f, 32'h1, 32'hffffff, 32'h0};

	t1_fault_conditioning_idle_insert #(.RESTORE_SHORT_CYC(20), .RESTORE_LONG_CYC(50))
	t1_fault_conditioning_idle_insert_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pkt_valid, .pkt_ready, .pkt_data,
		.pkt_sig, .tx_slot_req, .tx_slot_idx, .tx_valid, .tx_data, .tx_sig, .tx_ais,
		.rx_valid, .rx_data, .rx_sig, .line_los, .line_lof, .line_ais, .ip_valid,
		.ip_data, .ip_sig, .framer_line_type, .framer_cas_mode, .red_alarm);
	t1_line_model t1_line_model_inst (.pclk, .tx_slot_req, .tx_slot_idx, .tx_valid,
		.tx_data, .tx_sig, .tx_ais, .rx_valid, .rx_data, .rx_sig);

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic close_out();
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			err_count++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Expected framed slot answer: {ais, sig, data}
	function automatic logic [12:0] exp_tx(input logic used, input logic flt,
		input logic [11:0] f);
		logic [12:0] r;
		r = !used ? {5'h0, idle} : flt ? {1'b0, cs, cd} : {1'b0, f};
		if (!cas)
			r[11:8] = 4'h0;
		else if (lt == 2'h0)
			r[11:8] = r[11:8] & 4'h3;
		return r;
	endfunction : exp_tx

	task automatic slot(input logic [12:0] x);
		t1_line_model_inst.ask(k[4:0], ans, ok);
		check("tx answer", {ok, ans}, {1'b1, x});
	endtask : slot

	task automatic push(input logic [11:0] b);
		@(posedge pclk);
		pkt_valid <= 1'b1;
		{pkt_sig, pkt_data} <= b;
	endtask : push

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pkt_valid, pkt_data, pkt_sig} = '0;
		{line_los, line_lof, line_ais, presetn, err_count, cmp_count} = '0;
		seed = 32'h2824;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check("line type", framer_line_type, 2'h1);
		check("cas mode", framer_cas_mode, 1'b1);
		for (i = 0; i < 6; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			check("reset value", {er, rd}, {i == 5, rv[i]});
		end
		idle = $random(seed);
		cd = $random(seed);
		cs = 4'h1 + 4'({$random(seed)} % 15);
		k = {$random(seed)} % 24;
		apb(1'b1, 8'h04, {24'h0, idle});
		apb(1'b1, 8'h08, {24'h0, cd});
		apb(1'b1, 8'h0c, {28'h0, cs});
		apb(1'b1, 8'h10, 32'hffffff ^ (32'h1 << k));
		lt = 2'h1;
		cas = 1'b1;
		slot(exp_tx(1'b0, 1'b1, 12'h0));
		k = (k + 1) % 24;
		slot(exp_tx(1'b1, 1'b1, 12'h0));
		for (i = 0; i < 33; i++)
		begin
			v = $random(seed);
			if (i < 32)
				q.push_back(v);
			push(v);
		end
		@(posedge pclk);
		pkt_valid <= 1'b0;
		@(negedge pclk);
		check("pkt_ready", pkt_ready, 1'b0);
		slot(exp_tx(1'b1, 1'b1, 12'h0));
		void'(q.pop_front());
		while (q.size() > 0)
			slot(exp_tx(1'b1, 1'b0, q.pop_front()));
		apb(1'b1, 8'h00, 32'h1);
		cas = 1'b0;
		@(negedge pclk);
		check("cas mode", framer_cas_mode, 1'b0);
		slot(exp_tx(1'b1, 1'b1, 12'h0));
		cas = 1'b1;
		for (lt = 2'h0; lt < 2'h2; lt++)
		begin
			apb(1'b1, 8'h00, {28'h0, lt[0], 1'b1, lt});
			for (i = 0; i < 4; i++)
			begin
				@(posedge pclk);
				{line_los, line_lof, line_ais} <= 3'((4'h1 << i) >> 1);
				v = $random(seed) & (lt == 2'h0 ? 12'h3ff : 12'hfff);
				e = exp_tx(1'b1, 1'b1, 12'h0);
				t1_line_model_inst.send(v);
				check("ip", {ip_sig, ip_data}, i == 0 ? v : e[11:0]);
			end
			@(posedge pclk);
			{line_los, line_lof, line_ais} <= 3'h0;
			repeat (10) @(negedge pclk);
			check("red", red_alarm, 1'b1);
			repeat (25) @(negedge pclk);
			check("red", red_alarm, lt[0]);
			repeat (35) @(negedge pclk);
			check("red", red_alarm, 1'b0);
		end
		apb(1'b1, 8'h00, 32'h6);
		@(negedge pclk);
		check("mode", {framer_line_type, framer_cas_mode}, 3'h4);
		t1_line_model_inst.ask(5'h0, ans, ok);
		check("ais", {ans[12], ans[7:0]}, 9'h1ff);
		v = $random(seed);
		push(v);
		@(posedge pclk);
		pkt_valid <= 1'b0;
		t1_line_model_inst.ask(5'h0, ans, ok);
		check("ais", {ans[12], ans[7:0]}, {1'b0, v[7:0]});
		push(v);
		line_los <= 1'b1;
		@(posedge pclk);
		pkt_valid <= 1'b0;
		t1_line_model_inst.send(v);
		check("ip", {ip_sig, ip_data}, 12'h0ff);
		t1_line_model_inst.ask(5'h0, ans, ok);
		check("ais", {ans[12], ans[7:0]}, 9'h1ff);
		@(posedge pclk);
		line_los <= 1'b0;
		t1_line_model_inst.send(~v);
		check("ip", {ip_sig, ip_data}, {4'h0, ~v[7:0]});
		close_out();
	end
endmodule : t1_fault_conditioning_idle_insert_tb_top
`default_nettype wire
